// ### logic/aost_line.sv
`timescale 1ns/1ns
`include "aost_params.svh"
// one alarm line: latch or track behaviour before polarity is applied
module aost_line
  import aost_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // events
  input  wire logic track_mode,
  input  wire logic hit,
  input  wire logic in_limits,
  input  wire logic clear,
  // state
  output logic      active
);
  logic active_next;

  // a new crossing wins over a same-cycle clear so no alarm is lost
  assign active_next = hit ? 1'b1 :
                       clear ? 1'b0 :
                       (track_mode && in_limits) ? 1'b0 : active;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= active_next;
    end
  end
endmodule

// ### logic/aost_params.svh
`ifndef AOST_PARAMS_SVH
`define AOST_PARAMS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define AOST_ADDR_CTRL     8'h00
`define AOST_ADDR_CLEAR    8'h04
`define AOST_ADDR_LINES    8'h08
`define AOST_ADDR_STATUS   8'h0C
`define AOST_ADDR_MASK     8'h10
`define AOST_ADDR_MAP_LO   8'h14
`define AOST_ADDR_MAP_HI   8'h18
`define AOST_ADDR_LASTCODE 8'h1C
// ****************************************
// control register fields
// ****************************************
`define AOST_CTRL_TRACK    0
`define AOST_CTRL_APOL     1
`define AOST_CTRL_SPOL     2
`define AOST_CTRL_IMETER   3
// clear register: bit 4 clears all, bits 3:0 clear single lines
`define AOST_CLR_ALL       4
// ****************************************
// reset values and encodings
// ****************************************
`define AOST_CTRL_RST      4'h8
`define AOST_MASK_RST      3'h0
// pin idle levels for the reset polarity settings (both active low)
`define AOST_ALARM_RST     4'hF
`define AOST_STROBE_RST    1'h1
`define AOST_CODE_NONE     2'h0
`define AOST_CODE_LO       2'h1
`define AOST_CODE_HI       2'h2
`define AOST_SLVERR        2'h2
`define AOST_OKAY          2'h0
// status bits: 0 alarm raised, 1 strobe issued, 2 scan started
`define AOST_ST_ALARM      0
`define AOST_ST_STROBE     1
`define AOST_ST_SCAN       2
`endif

// ### logic/aost_pkg.sv
package aost_pkg;
  typedef enum logic [1:0] {
    AOST_PULSE_IDLE = 2'b01,
    AOST_PULSE_HIGH = 2'b10
  } aost_pulse_t;
  typedef logic [1:0] aost_code_t;
endpackage

// ### logic/aost_strobe.sv
`timescale 1ns/1ns
`include "aost_params.svh"
// channel-closed strobe: one-clock pulse of selectable active level
module aost_strobe
  import aost_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic fire,
  input  wire logic strobe_active_high,
  // pin
  output logic      strobe_pin
);
  aost_pulse_t state_reg;
  aost_pulse_t state_next;

  // pulse lasts one cycle, then returns to idle level
  always_comb begin
    case (state_reg)
      AOST_PULSE_IDLE: state_next = fire ? AOST_PULSE_HIGH : AOST_PULSE_IDLE;
      AOST_PULSE_HIGH: state_next = AOST_PULSE_IDLE;
      default:         state_next = AOST_PULSE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg  <= AOST_PULSE_IDLE;
      strobe_pin <= `AOST_STROBE_RST; // R14
    end else begin
      state_reg  <= state_next;
      // active edge is the leading edge of the pulse
      strobe_pin <= (state_next == AOST_PULSE_HIGH) ~^ strobe_active_high;
    end
  end
endmodule

// ### logic/aost_top.sv
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "aost_params.svh"
// Contract
// R1 - a clear-all request drops all four alarm lines at once.
// R2 - a single-line clear naming line 1 to 4 drops only that line.
// R3 - clears are taken at any time and never erase stored alarm codes.
// R4 - starting a new scan discards the stored alarm codes.
// R5 - each channel maps to one alarm line and reports only there.
// R6 - digital pattern match or change and totalizer count reached raise alarms.
// R7 - latch mode holds a line until clear, new scan or reset.
// R8 - track mode drops a line automatically once a reading is within limits.
// R9 - one polarity setting drives all four lines, low or high when active.
// R10 - the strobe's active edge is rising or falling per its polarity setting.
// R11 - with the internal meter the strobe fires at each sweep end only.
// R12 - with the internal meter off the strobe fires at each channel closure.
// R13 - each reading carries alarm code 0 none, 1 low, 2 high.
// R14 - after reset every line and the strobe sit at their inactive level.
module aost_top
  import aost_pkg::*;
#(
  parameter int CHANNELS = 16
)
(
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // axi4-lite write address
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // measurement results from the scan engine
  input  wire logic                        reading_valid,
  input  wire logic [$clog2(CHANNELS)-1:0] reading_channel,
  input  wire logic                        reading_low,
  input  wire logic                        reading_high,
  input  wire logic                        digital_event,
  // scan sequencing
  input  wire logic                        scan_start,
  input  wire logic                        sweep_end,
  input  wire logic                        channel_closed,
  // stored alarm code of the last reading
  output logic [1:0]                       reading_code,
  output logic                             reading_code_valid,
  // connector pins
  output logic [3:0]                       alarm_out,
  output logic                             channel_closed_strobe,
  // interrupt
  output logic                             irq
);
  initial begin
    if (CHANNELS < 2 || CHANNELS > 16) begin
      $error("CHANNELS must be 2..16");
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [3:0]            ctrl_reg;
  logic [31:0]           map_reg;
  logic [2:0]            status_reg;
  logic [2:0]            status_next;
  logic [2:0]            mask_reg;
  logic [1:0]            code_reg;
  logic [1:0]            code_next;
  logic                  code_valid_reg;
  logic [3:0]            alarm_reg;
  logic [3:0]            line_active;
  logic                  irq_reg;

  wire track_mode         = ctrl_reg[`AOST_CTRL_TRACK];
  wire alarm_active_high  = ctrl_reg[`AOST_CTRL_APOL];
  wire strobe_active_high = ctrl_reg[`AOST_CTRL_SPOL];
  wire internal_meter_select = ctrl_reg[`AOST_CTRL_IMETER];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // the slave holds each half until both are present, then answers
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  wire wr_ctrl  = wr_fire && (aw_addr_reg == `AOST_ADDR_CTRL);
  wire wr_clear = wr_fire && (aw_addr_reg == `AOST_ADDR_CLEAR);
  wire wr_mask  = wr_fire && (aw_addr_reg == `AOST_ADDR_MASK);
  wire wr_maplo = wr_fire && (aw_addr_reg == `AOST_ADDR_MAP_LO);
  wire wr_maphi = wr_fire && (aw_addr_reg == `AOST_ADDR_MAP_HI);
  wire wr_known = wr_ctrl || wr_clear || wr_mask || wr_maplo || wr_maphi;
  wire rd_status = ar_take && (s_axi_araddr == `AOST_ADDR_STATUS);

  // byte-lane merge, used for every writable register except the clear register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] ctrl_merged = merge({28'h0000000, ctrl_reg}, w_data_reg, w_strb_reg);
  wire [31:0] mask_merged = merge({29'h00000000, mask_reg}, w_data_reg, w_strb_reg);

  // read mux; unmapped addresses answer slverr with zero data
  logic [31:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr == `AOST_ADDR_CTRL) begin
      rd_data = {28'h0000000, ctrl_reg};
    end else if (s_axi_araddr == `AOST_ADDR_CLEAR) begin
      rd_data = 32'h00000000;
    end else if (s_axi_araddr == `AOST_ADDR_LINES) begin
      rd_data = {28'h0000000, line_active};
    end else if (s_axi_araddr == `AOST_ADDR_STATUS) begin
      rd_data = {29'h00000000, status_reg};
    end else if (s_axi_araddr == `AOST_ADDR_MASK) begin
      rd_data = {29'h00000000, mask_reg};
    end else if (s_axi_araddr == `AOST_ADDR_MAP_LO) begin
      rd_data = {16'h0000, map_reg[15:0]};
    end else if (s_axi_araddr == `AOST_ADDR_MAP_HI) begin
      rd_data = {16'h0000, map_reg[31:16]};
    end else if (s_axi_araddr == `AOST_ADDR_LASTCODE) begin
      rd_data = {29'h00000000, code_valid_reg, code_reg};
    end else begin
      rd_data = 32'h00000000;
      rd_ok   = 1'b0;
    end
  end

  // write channels
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AOST_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take;
      s_axi_wready  <= !w_held && !w_take;
      if (aw_take) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `AOST_OKAY : `AOST_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AOST_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? `AOST_OKAY : `AOST_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // map halves are 16 bits; only the low half of the merged word is kept
  wire [31:0] maplo_merged = merge({16'h0000, map_reg[15:0]}, w_data_reg, w_strb_reg);
  wire [31:0] maphi_merged = merge({16'h0000, map_reg[31:16]}, w_data_reg, w_strb_reg);

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= `AOST_CTRL_RST;
      mask_reg <= `AOST_MASK_RST;
      map_reg  <= 32'h00000000;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_merged[3:0];
      if (wr_mask) mask_reg <= mask_merged[2:0];
      if (wr_maplo) map_reg[15:0] <= maplo_merged[15:0];
      if (wr_maphi) map_reg[31:16] <= maphi_merged[15:0];
    end
  end

  // ****************************************
  // alarm routing
  // ****************************************
  // two bits per channel select the line; channels above 16 never exist
  wire [1:0] sel_line = map_reg[{reading_channel, 1'b0} +: 2]; // R5
  wire out_of_lim = reading_low || reading_high;
  wire raise      = reading_valid && (out_of_lim || digital_event); // R6
  wire in_lim     = reading_valid && !out_of_lim && !digital_event;

  // clear-all ored into each per-line clear; scan start clears too
  wire [3:0] clr_bits = w_data_reg[3:0] & {4{wr_clear}};
  wire       clr_all  = wr_clear && w_data_reg[`AOST_CLR_ALL];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_line
      aost_line u_line (
        .core_clk  (core_clk),
        .rst       (rst),
        .track_mode(track_mode),
        .hit       (raise && (sel_line == 2'(g))),                    // R5
        .in_limits (in_lim && (sel_line == 2'(g))),                   // R8
        .clear     (clr_all || clr_bits[g] || scan_start),            // R1 R2 R7
        .active    (line_active[g])
      );
    end
  endgenerate

  // polarity applied at the pin flops; reset gives the inactive level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_reg <= `AOST_ALARM_RST;                                   // R14
    end else begin
      alarm_reg <= alarm_active_high ? line_active : ~line_active;    // R9
    end
  end
  assign alarm_out = alarm_reg;

  // ****************************************
  // stored alarm code
  // ****************************************
  // clears of alarm lines never touch this; only scan start and reset do
  assign code_next = reading_high ? `AOST_CODE_HI :
                     reading_low  ? `AOST_CODE_LO : `AOST_CODE_NONE;  // R13
  always_ff @(posedge core_clk) begin
    if (rst || scan_start) begin
      code_reg       <= `AOST_CODE_NONE;                              // R4
      code_valid_reg <= 1'b0;
    end else if (reading_valid) begin
      code_reg       <= code_next;                                    // R3
      code_valid_reg <= 1'b1;
    end
  end
  assign reading_code       = code_reg;
  assign reading_code_valid = code_valid_reg;

  // ****************************************
  // channel-closed strobe
  // ****************************************
  wire strobe_fire = internal_meter_select ? sweep_end                // R11
                                           : channel_closed;          // R12
  aost_strobe u_strobe (
    .core_clk          (core_clk),
    .rst               (rst),
    .fire              (strobe_fire),
    .strobe_active_high(strobe_active_high),                          // R10
    .strobe_pin        (channel_closed_strobe)
  );

  // ****************************************
  // interrupt status, cleared by read; new events win
  // ****************************************
  wire [2:0] evt = {scan_start, strobe_fire, raise};
  assign status_next = (rd_status ? 3'h0 : status_reg) | evt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= 3'h0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
    end
  end
  assign irq = irq_reg;
endmodule

// ### tb/aost_far_end.sv
`timescale 1ns/1ns
// ****
// far-end equipment: a meter triggered by the strobe
// ****
module aost_far_end (
  // clock
  input  wire logic core_clk,
  // connector
  input  wire logic channel_closed_strobe,
  input  wire logic strobe_active_high,
  // measurements taken
  output int        trig_count
);
  initial trig_count = 0;
  // one measurement per cycle at the active level
  always @(posedge core_clk) begin
    if (channel_closed_strobe === strobe_active_high)
      trig_count <= trig_count + 1;
  end
endmodule

// ### tb/aost_top_asserts.sv
`timescale 1ns/1ns
`include "aost_params.svh"
// ****
// port checker
// ****
module aost_top_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // scan engine
  input wire logic       reading_valid,
  input wire logic       reading_low,
  input wire logic       reading_high,
  input wire logic       digital_event,
  input wire logic       scan_start,
  input wire logic       sweep_end,
  input wire logic       channel_closed,
  // outputs
  input wire logic [1:0] reading_code,
  input wire logic [3:0] alarm_out,
  input wire logic       channel_closed_strobe,
  input wire logic       irq
);
  logic [2:0] quiet_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since anything that may move a line; saturates
  always_ff @(posedge core_clk) begin
    if (rst || reading_valid || scan_start || s_axi_awvalid || s_axi_wvalid || s_axi_bvalid)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  AST_RST_IDLE: assert property (disable iff (1'h0)
    rst |=> alarm_out == `AOST_ALARM_RST && !irq
    && channel_closed_strobe == `AOST_STROBE_RST)
    else $error("outputs not idle after reset");
  AST_SCAN_CODE: assert property (
    scan_start && !reading_valid |=> reading_code == `AOST_CODE_NONE)
    else $error("stored code survives a new scan");
  AST_CODE_HI: assert property (
    reading_valid && reading_high && !scan_start |=> reading_code == `AOST_CODE_HI)
    else $error("high crossing not coded 2");
  AST_CODE_LO: assert property (
    reading_valid && reading_low && !reading_high && !scan_start
    |=> reading_code == `AOST_CODE_LO) else $error("low crossing not coded 1");
  AST_CODE_NONE: assert property (
    reading_valid && !reading_low && !reading_high && !digital_event && !scan_start
    |=> reading_code == `AOST_CODE_NONE) else $error("in-limit reading not coded 0");
  // a pulse only follows a sweep end or a closure
  AST_STROBE_CAUSE: assert property (
    channel_closed_strobe != $past(channel_closed_strobe)
    && channel_closed_strobe == $past(channel_closed_strobe, 2)
    |-> $past(sweep_end, 2) || $past(channel_closed, 2)
    || $past(sweep_end, 3) || $past(channel_closed, 3)) else $error("strobe without cause");
  AST_ALARM_HOLD: assert property (
    quiet_reg >= 3'h4 |-> $stable(alarm_out)) else $error("alarm lines moved unprompted");
  AST_SCAN_LINES: assert property (
    scan_start && !reading_valid && !$past(reading_valid)
    |=> ##1 (alarm_out == 4'h0 || alarm_out == 4'hF)) else $error("scan left a line set");
  AST_READ_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_WRITE_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
endmodule
bind aost_top aost_top_chk i_chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .reading_valid, .reading_low, .reading_high, .digital_event, .scan_start, .sweep_end,
  .channel_closed, .reading_code, .alarm_out, .channel_closed_strobe, .irq);

// ### tb/tb_alarm_output_and_scan_trigger.sv
`timescale 1ns/1ns
`include "aost_params.svh"
module tb_alarm_output_and_scan_trigger
  import aost_pkg::*;
;
  typedef struct packed {
    logic [3:0] ch;
    logic [2:0] lhd;
    logic [1:0] code;
    logic [3:0] act;
  } aost_row_t;
  // channel, {low, high, pattern}, code, lines set
  aost_row_t rows [5] = '{'{4'h0, 3'h2, 2'h2, 4'h1}, '{4'h1, 3'h4, 2'h1, 4'h2},
    '{4'h2, 3'h6, 2'h2, 4'h4}, '{4'h3, 3'h0, 2'h0, 4'h0}, '{4'h3, 3'h1, 2'h0, 4'h8}};
  // ctrl, {sweep end, closure, triggers}
  logic [6:0] srows [6] = '{{4'hC, 3'h5}, {4'hC, 3'h2}, {4'h4, 3'h3}, {4'h4, 3'h4},
    {4'h8, 3'h5}, {4'h0, 3'h3}};
  logic        core_clk, rst, spol;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, reading_channel, alarm_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reading_code, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, reading_valid, reading_low, reading_high;
  logic        digital_event, scan_start, sweep_end, channel_closed;
  logic        reading_code_valid, channel_closed_strobe, irq;
  int          fail_count, total_checks, cyc, trig_count, c0;
  aost_top i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reading_valid, .reading_channel,
    .reading_low, .reading_high, .digital_event, .scan_start, .sweep_end, .channel_closed,
    .reading_code, .reading_code_valid, .alarm_out, .channel_closed_strobe, .irq);
  aost_far_end i_far (.core_clk, .channel_closed_strobe, .strobe_active_high(spol),
    .trig_count);
  // ****
  // clock, timeout and tasks
  // ****
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // a hang ends the run as a failure
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // each task starts on a fresh edge so no signal is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdg(input logic [3:0] ch, input logic [2:0] lhd);
    @(posedge core_clk);
    {reading_valid, reading_channel, reading_low, reading_high, digital_event} <= {1'h1, ch, lhd};
    @(posedge core_clk);
    {reading_valid, digital_event} <= 2'h0;
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge core_clk);
    {scan_start, sweep_end, channel_closed} <= p;
    @(posedge core_clk);
    {scan_start, sweep_end, channel_closed} <= 3'h0;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, reading_channel} = '0;
    {reading_valid, reading_low, reading_high, digital_event, spol} = '0;
    {scan_start, sweep_end, channel_closed, fail_count, total_checks, cyc} = '0;
    tick(6);
    rst <= 1'h0;
    tick(3);
    chk({alarm_out, channel_closed_strobe}, 5'h1F);
    rd(`AOST_ADDR_CTRL);
    chk(rdat, 32'h8);
    rd(`AOST_ADDR_MASK);
    chk(rdat, 32'h0);
    wr(`AOST_ADDR_MAP_LO, 32'hE4);
    foreach (rows[i]) begin
      pulse(3'h4);
      tick(3);
      chk(alarm_out, 4'hF);
      chk({reading_code_valid, reading_code}, {1'h0, `AOST_CODE_NONE});
      rdg(rows[i].ch, rows[i].lhd);
      tick(3);
      chk(alarm_out, 4'(~rows[i].act));
      if (!rows[i].lhd[0])
        chk({reading_code_valid, reading_code}, {1'h1, rows[i].code});
    end
    // latched lines survive an in-limit reading
    pulse(3'h4);
    rdg(4'h0, 3'h4);
    rdg(4'h0, 3'h0);
    rdg(4'h2, 3'h2);
    tick(3);
    chk(alarm_out, 4'hA);
    rd(`AOST_ADDR_LINES);
    chk(rdat, 32'h5);
    wr(`AOST_ADDR_CLEAR, 32'h4);
    tick(3);
    chk(alarm_out, 4'hE);
    wr(`AOST_ADDR_CTRL, 32'hA);
    tick(3);
    chk(alarm_out, 4'h1);
    wr(`AOST_ADDR_CLEAR, 32'h10);
    tick(3);
    chk(alarm_out, 4'h0);
    chk(reading_code, `AOST_CODE_HI);
    wr(`AOST_ADDR_CTRL, 32'hB);
    rdg(4'h1, 3'h4);
    tick(3);
    chk(alarm_out, 4'h2);
    rdg(4'h1, 3'h0);
    tick(3);
    chk(alarm_out, 4'h0);
    // interrupt raised, read away, then masked
    rd(`AOST_ADDR_STATUS);
    wr(`AOST_ADDR_MASK, 32'h1);
    rdg(4'h0, 3'h2);
    tick(3);
    chk(irq, 1'h1);
    rd(`AOST_ADDR_STATUS);
    chk(rdat & 32'h1, 32'h1);
    tick(3);
    chk(irq, 1'h0);
    wr(`AOST_ADDR_MASK, 32'h0);
    rdg(4'h0, 3'h2);
    tick(3);
    chk(irq, 1'h0);
    rd(8'h20);
    chk({resp, rdat}, {`AOST_SLVERR, 32'h0});
    wr(8'h24, 32'h1);
    chk(resp, `AOST_SLVERR);
    foreach (srows[i]) begin
      wr(`AOST_ADDR_CTRL, {28'h0, srows[i][6:3]});
      spol <= srows[i][5];
      tick(3);
      chk(channel_closed_strobe, !srows[i][5]);
      c0 = trig_count;
      pulse({1'h0, srows[i][2:1]});
      tick(3);
      chk(trig_count - c0, srows[i][0]);
    end
    // mid-run reset: active-high pins must fall back to the reset idle levels
    wr(`AOST_ADDR_CTRL, 32'h6);
    @(posedge core_clk);
    rst <= 1'h1;
    tick(2);
    chk({alarm_out, channel_closed_strobe}, 5'h1F);
    rst <= 1'h0;
    tick(2);
    chk({alarm_out, channel_closed_strobe, irq}, 6'h3E);
    summarize();
  end
endmodule
